// *** rtl/mrl_pkg.sv ***
`default_nettype none
package mrl_pkg;
  // ==========================================================
  // register map (byte addresses, word aligned)
  localparam logic [3:0]  OFS_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_LIMIT    = 4'h4;
  localparam logic [3:0]  OFS_COUNT    = 4'h8;
  localparam logic [3:0]  OFS_STATUS   = 4'hC;
  localparam logic [3:0]  OFS_MASK     = 4'h0; // word 4 via bank bit
  localparam logic [4:0]  ADDR_MASK    = 5'h10;
  // ==========================================================
  // fields
  localparam int          CTRL_DIR     = 0;
  localparam int          CTRL_CLEAR   = 1;
  localparam int          ST_MISMATCH  = 0;
  localparam int          ST_WRAP      = 1;
  localparam int          ST_CLEARED   = 2;
  localparam int          NUM_EVENTS   = 3;
  // ==========================================================
  // reset values and limits
  localparam logic [15:0] LIMIT_RESET  = 16'h0000;
  localparam logic [15:0] LIMIT_MAX    = 16'h7530;
  localparam logic        DIR_RESET    = 1'b0;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAXPOS = 16'h7FFF;
  localparam logic [15:0] COUNT_MAXNEG = 16'h8000;
  localparam logic        DIR_CCW      = 1'b0;
  localparam logic        DIR_CW       = 1'b1;
endpackage : mrl_pkg
`default_nettype wire

// *** rtl/mrl_multiturn.sv ***
`default_nettype none
// How it works
// - the turn count is a signed 16-bit value from -32768 to +32767.
// - with no limit, counting up past +32767 wraps to -32768.
// - with a limit set, the count wraps at the limit and stays in ratio.
// - the limit accepts 0 to 30000, resets to 0, larger writes clamp.
// - direction select 0 means CCW running and 1 means CW, reset 0.
// - direction select sets the zero value that a clear loads while limit wrapping acts.
// - a clear request from software or the clear pin loads the count with 0, or with the zero value while limit wrapping acts.
// - a turn against the selected direction raises the mismatch alarm when an absolute encoder is fitted.
// - limit wrapping acts only when an absolute encoder is fitted.
module mrl_multiturn
  import mrl_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // encoder side pins
  input  wire logic        abs_encoder,
  input  wire logic        turn_cw,
  input  wire logic        turn_ccw,
  input  wire logic        multiturn_clear_function,
  // results
  output var  logic [15:0] turn_count,
  output var  logic        direction_mismatch_alarm,
  output var  logic        irq
);

  // ==========================================================
  // pin synchronisers
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       clr_pin_d;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      clr_pin_d <= 1'b0;
    end
    else
    begin
      sync1 <= {multiturn_clear_function, turn_ccw, turn_cw, abs_encoder};
      sync2 <= sync1;
      clr_pin_d <= sync2[3];
    end
  end

  logic abs_s;
  logic cw_s;
  logic ccw_s;
  logic clr_pin_rise;
  assign abs_s        = sync2[0];
  assign cw_s         = sync2[1] & ~sync2[2];
  assign ccw_s        = sync2[2] & ~sync2[1];
  assign clr_pin_rise = sync2[3] & ~clr_pin_d;

  // ==========================================================
  // bus slave: one cycle wait then answer
  logic        req;
  logic        ack;
  logic        limit_select_dir;
  logic [15:0] rev_limit;
  logic [NUM_EVENTS-1:0] status;
  logic [NUM_EVENTS-1:0] mask;
  logic        sw_clear;

  assign req = (avs_read | avs_write) & ~ack;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= req;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~req;
  end

  logic wr_en;
  assign wr_en = avs_write & ack;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rev_limit        <= LIMIT_RESET;
      limit_select_dir <= DIR_RESET;
    end
    else if (wr_en && avs_address == {1'b0, OFS_LIMIT})
    begin
      if (avs_writedata[15:0] > LIMIT_MAX)
        rev_limit <= LIMIT_MAX;
      else
        rev_limit <= avs_writedata[15:0];
    end
    else if (wr_en && avs_address == {1'b0, OFS_CTRL})
      limit_select_dir <= avs_writedata[CTRL_DIR];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      mask <= '0;
    else if (wr_en && avs_address == ADDR_MASK)
      mask <= avs_writedata[NUM_EVENTS-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sw_clear <= 1'b0;
    else
      sw_clear <= wr_en && avs_address == {1'b0, OFS_CTRL}
                  && avs_writedata[CTRL_CLEAR];
  end

  logic [31:0] next_readdata;
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      {1'b0, OFS_CTRL}:   next_readdata = {31'h0, limit_select_dir};
      {1'b0, OFS_LIMIT}:  next_readdata = {16'h0, rev_limit};
      {1'b0, OFS_COUNT}:  next_readdata = {16'h0, turn_count};
      {1'b0, OFS_STATUS}: next_readdata = {29'h0, status};
      ADDR_MASK:          next_readdata = {29'h0, mask};
      default:            next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && req)
      avs_readdata <= next_readdata;
  end

  // ==========================================================
  // turn counter
  logic        clear_req;
  logic        limit_on;
  logic        up;
  logic        down;
  logic [15:0] zero_val;
  logic [15:0] top_val;
  logic [15:0] next_count;
  logic        wrap_evt;
  logic        mism_evt;

  assign clear_req = sw_clear | clr_pin_rise;
  assign limit_on  = abs_s && rev_limit != 16'h0000;
  assign up        = cw_s;
  assign down      = ccw_s;
  // zero at start of range for the selected direction
  assign top_val   = rev_limit - 16'h0001;
  assign zero_val  = limit_select_dir == DIR_CW ? 16'h0000 : top_val;
  assign mism_evt  = (limit_select_dir == DIR_CW) ? down : up;

  always_comb
  begin
    next_count = turn_count;
    wrap_evt   = 1'b0;
    if (limit_on)
    begin
      if (up && turn_count >= top_val)
      begin
        next_count = 16'h0000;
        wrap_evt   = 1'b1;
      end
      else if (down && turn_count == 16'h0000)
      begin
        next_count = top_val;
        wrap_evt   = 1'b1;
      end
      else if (up)
        next_count = turn_count + 16'h0001;
      else if (down)
        next_count = turn_count - 16'h0001;
    end
    else
    begin
      if (up)
        next_count = turn_count + 16'h0001;
      else if (down)
        next_count = turn_count - 16'h0001;
      wrap_evt = (up && turn_count == COUNT_MAXPOS)
                 || (down && turn_count == COUNT_MAXNEG);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      turn_count <= COUNT_RESET;
    else if (clear_req)
      turn_count <= limit_on ? zero_val : COUNT_RESET;
    else
      turn_count <= next_count;
  end

  // ==========================================================
  // alarm and interrupt
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      direction_mismatch_alarm <= 1'b0;
    else if (mism_evt && abs_s)
      direction_mismatch_alarm <= 1'b1;
    else if (clear_req)
      direction_mismatch_alarm <= 1'b0;
  end

  logic [NUM_EVENTS-1:0] evt;
  assign evt[ST_MISMATCH] = mism_evt & abs_s;
  assign evt[ST_WRAP]     = wrap_evt & ~clear_req;
  assign evt[ST_CLEARED]  = clear_req;

  logic [NUM_EVENTS-1:0] w1c;
  assign w1c = (wr_en && avs_address == {1'b0, OFS_STATUS})
               ? avs_writedata[NUM_EVENTS-1:0] : '0;

  // set wins over clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      status <= '0;
    else
      status <= (status & ~w1c) | evt;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(((status & ~w1c) | evt) & mask);
  end

  // ==========================================================
  // checks
  a_limit_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
    rev_limit <= LIMIT_MAX)
    else $error("limit above maximum");
  a_plain_overflow: assert property (@(posedge mclk) disable iff (!rst_n)
    !limit_on && !clear_req && up && turn_count == COUNT_MAXPOS
    |=> turn_count == COUNT_MAXNEG)
    else $error("no overflow wrap");
  a_limit_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    limit_on && !clear_req && up && turn_count == top_val
    |=> turn_count == 16'h0000)
    else $error("no wrap at limit");
  a_limit_range: assert property (@(posedge mclk) disable iff (!rst_n)
    limit_on && $stable(rev_limit) && $past(limit_on)
    && $past(turn_count) < $past(rev_limit)
    |-> turn_count < rev_limit)
    else $error("count left limit range");
  a_clear_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    clear_req && !limit_on |=> turn_count == COUNT_RESET)
    else $error("clear missed");
  a_clear_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    clear_req && limit_on |=> turn_count == $past(zero_val))
    else $error("clear zero wrong");
  a_mismatch_alarm: assert property (@(posedge mclk) disable iff (!rst_n)
    mism_evt && abs_s |=> direction_mismatch_alarm)
    else $error("alarm missed");
  a_dir_decode: assert property (@(posedge mclk) disable iff (!rst_n)
    limit_select_dir == DIR_CCW && cw_s && abs_s
    |=> direction_mismatch_alarm)
    else $error("direction decode");
  a_no_abs: assert property (@(posedge mclk) disable iff (!rst_n)
    !abs_s && !clear_req && up && turn_count != COUNT_MAXPOS
    |=> turn_count == $past(turn_count) + 16'h0001)
    else $error("limit active without encoder");
  a_zero_limit: assert property (@(posedge mclk) disable iff (!rst_n)
    rev_limit == 16'h0000 && !clear_req && down
    && turn_count != COUNT_MAXNEG
    |=> turn_count == $past(turn_count) - 16'h0001)
    else $error("zero limit wraps");
  a_range_span: assert property (@(posedge mclk) disable iff (!rst_n)
    !limit_on && !clear_req && down && turn_count == COUNT_MAXNEG
    |=> turn_count == COUNT_MAXPOS)
    else $error("negative end wrong");
  c_wrap: cover property (@(posedge mclk) wrap_evt && limit_on);
  c_overflow: cover property (@(posedge mclk) wrap_evt && !limit_on);
  c_alarm: cover property (@(posedge mclk) $rose(direction_mismatch_alarm));
  c_irq: cover property (@(posedge mclk) $rose(irq));

endmodule : mrl_multiturn
`default_nettype wire

// *** sim/mrl_host.sv ***
`default_nettype none
module mrl_host
  import mrl_pkg::*;
(
  // bus
  input  wire logic        mclk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output var  logic [4:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
  end
  // ==========================================================
  // bus cycle, held until waitrequest low
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  // ==========================================================
  // set limit, then direction, then clear
  task automatic cfg(input logic [31:0] lim, input logic dir);
    logic [31:0] q;
    xfer(1'b1, {1'b0, OFS_LIMIT}, lim, q);
    xfer(1'b1, {1'b0, OFS_CTRL}, {31'h0, dir}, q);
    xfer(1'b1, {1'b0, OFS_CTRL}, {30'h0, 1'b1, dir}, q);
  endtask : cfg
endmodule : mrl_host
`default_nettype wire

// *** sim/tb_multiturn_revolution_limit.sv ***
`default_nettype none
module tb_multiturn_revolution_limit
  import mrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic abs; logic [31:0] lim; logic dir; int ncw; int nccw;
    logic [15:0] cnt; logic alm;
  } mrl_row_s;
  mrl_row_s rows [5] = '{
    '{1'b1, 32'h5, 1'b1, 7, 0, 16'h0002, 1'b0},
    '{1'b1, 32'h5, 1'b0, 0, 6, 16'h0003, 1'b0},
    '{1'b0, 32'h5, 1'b1, 0, 3, 16'hFFFD, 1'b0},
    '{1'b1, 32'h0, 1'b1, 0, 2, 16'hFFFE, 1'b1},
    '{1'b1, 32'h9C40, 1'b0, 1, 0, 16'h0000, 1'b1}};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        abs_encoder = 1'b0;
  logic        turn_cw = 1'b0;
  logic        turn_ccw = 1'b0;
  logic        multiturn_clear_function = 1'b0;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] turn_count;
  logic        direction_mismatch_alarm;
  logic        irq;
  int          bad_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [31:0] cnt32;
  logic [31:0] alm32;
  assign cnt32 = {16'h0, turn_count};
  assign alm32 = {31'h0, direction_mismatch_alarm};
  always #5 mclk = ~mclk;
  mrl_multiturn mrl_multiturn_i (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .abs_encoder(abs_encoder), .turn_cw(turn_cw), .turn_ccw(turn_ccw),
    .multiturn_clear_function(multiturn_clear_function),
    .turn_count(turn_count),
    .direction_mismatch_alarm(direction_mismatch_alarm), .irq(irq));
  mrl_host mrl_host_i (.mclk(mclk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata));
  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [31:0] e, g);
    checked = checked + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic turn(input int n, input logic cw);
    repeat (n)
    begin
      turn_cw  <= cw;
      turn_ccw <= !cw;
      @(posedge mclk);
      turn_cw  <= 1'b0;
      turn_ccw <= 1'b0;
      @(posedge mclk);
    end
    wt(5);
  endtask : turn
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // cycle ceiling
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] q;
    wt(16);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("count", 32'h0, {16'h0, turn_count});
    mrl_host_i.xfer(1'b0, {1'b0, OFS_LIMIT}, 32'h0, q);
    chk("limit", {16'h0, LIMIT_RESET}, q);
    mrl_host_i.xfer(1'b0, {1'b0, OFS_CTRL}, 32'h0, q);
    chk("dir", {31'h0, DIR_RESET}, {31'h0, q[CTRL_DIR]});
    mrl_host_i.xfer(1'b0, 5'h14, 32'h0, q);
    chk("unmapped", 32'h0, q);
    foreach (rows[i])
    begin
      abs_encoder <= rows[i].abs;
      mrl_host_i.cfg(rows[i].lim, rows[i].dir);
      wt(4);
      turn(rows[i].ncw, 1'b1);
      turn(rows[i].nccw, 1'b0);
      chk("count", {16'h0, rows[i].cnt}, cnt32);
      chk("alarm", {31'h0, rows[i].alm}, alm32);
      mrl_host_i.xfer(1'b0, {1'b0, OFS_COUNT}, 32'h0, q);
      chk("count reg", {16'h0, rows[i].cnt}, {16'h0, q[15:0]});
    end
    mrl_host_i.xfer(1'b0, {1'b0, OFS_LIMIT}, 32'h0, q);
    chk("limit clamp", {16'h0, LIMIT_MAX}, q);
    mrl_host_i.xfer(1'b0, {1'b0, OFS_STATUS}, 32'h0, q);
    chk("status all", 32'h7, q);
    abs_encoder <= 1'b0;
    mrl_host_i.cfg(32'h0, 1'b1);
    wt(4);
    chk("alarm clear", 32'h0, alm32);
    mrl_host_i.xfer(1'b1, {1'b0, OFS_STATUS}, 32'h7, q);
    turn(32768, 1'b1);
    chk("overflow", {16'h0, COUNT_MAXNEG}, cnt32);
    mrl_host_i.xfer(1'b0, {1'b0, OFS_STATUS}, 32'h0, q);
    chk("wrap flag", 32'h1, {31'h0, q[ST_WRAP]});
    chk("irq masked", 32'h0, {31'h0, irq});
    mrl_host_i.xfer(1'b1, ADDR_MASK, 32'h2, q);
    wt(2);
    chk("irq", 32'h1, {31'h0, irq});
    mrl_host_i.xfer(1'b1, {1'b0, OFS_STATUS}, 32'h2, q);
    wt(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    multiturn_clear_function <= 1'b1;
    wt(6);
    chk("pin clear", 32'h0, {16'h0, turn_count});
    multiturn_clear_function <= 1'b0;
    wt(2);
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("irq rst", 32'h0, {31'h0, irq});
    mrl_host_i.xfer(1'b0, {1'b0, OFS_STATUS}, 32'h0, q);
    chk("status rst", 32'h0, q);
    mrl_host_i.xfer(1'b0, ADDR_MASK, 32'h0, q);
    chk("mask rst", 32'h0, q);
    turn(1, 1'b1);
    chk("count rst", 32'h1, cnt32);
    end_of_test();
  end
endmodule : tb_multiturn_revolution_limit
`default_nettype wire
